// ---- src/bwd_top.v ----
/*
  Board supervisor: watchdog with four periods, front-panel reset switch,
  handle power button and override, backplane reset and power-good LED.
  Assumes a 25 MHz core clock, a strobe register port and active-low
  switch inputs from pins.
*/
// Chosen here: the plain strobed port and the register offsets.
`include "bwd_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module bwd_top #(
  parameter CLK_HZ     = `BWD_CLK_HZ,
  parameter TICK_CYC   = `BWD_CLK_HZ,
  parameter OVR_CYC    = `BWD_OVERRIDE_S * `BWD_CLK_HZ,
  parameter BLINK_CYC  = `BWD_CLK_HZ / (2 * `BWD_BLINK_HZ),
  parameter DEB_CYC    = `BWD_DEB_CYC,
  parameter PULSE_CYC  = `BWD_RST_PULSE_CYC
) (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   sys_rst,
  // Register port
  input  wire [`BWD_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // Front panel and backplane
  input  wire                   reset_switch_n,
  input  wire                   handle_button_n,
  input  wire                   handle_closed,
  input  wire                   backplane_reset_request_n,
  input  wire                   rails_good,
  // Events and indicator
  output reg                    system_reset_req,
  output reg                    power_button_pulse,
  output reg                    power_override,
  output reg                    soft_off,
  output reg                    power_good_indicator_green,
  output reg                    power_good_indicator_yellow
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire rsw_n;
  wire hbtn_n;
  wire hcl;
  wire bpr_n;
  wire rg;

  bwd_sync #(.RST_VAL(1'b1)) u_rsw (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(reset_switch_n), .pin_out(rsw_n));
  bwd_sync #(.RST_VAL(1'b1)) u_hbtn (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(handle_button_n), .pin_out(hbtn_n));
  bwd_sync #(.RST_VAL(1'b0)) u_hcl (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(handle_closed), .pin_out(hcl));
  bwd_sync #(.RST_VAL(1'b1)) u_bpr (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(backplane_reset_request_n), .pin_out(bpr_n));
  bwd_sync #(.RST_VAL(1'b0)) u_rg (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(rails_good), .pin_out(rg));

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [1:0] sel_q;
  reg [2:0] cfg_q;
  reg       active_q;
  reg [7:0] secs_q;
  reg [31:0] tick_cnt_q;
  reg       expired_q;

  wire wr_ctrl = reg_wr && (reg_addr == `BWD_REG_CTRL);
  wire wr_cfg  = reg_wr && (reg_addr == `BWD_REG_CFG);
  wire service = wr_ctrl && reg_wdata[`BWD_CTRL_SERVICE];
  wire tick    = (tick_cnt_q == TICK_CYC - 1);

  reg [7:0] period;
  always @* begin
    case (sel_q)
      `BWD_SEL_2S:  period = `BWD_PER_2S;
      `BWD_SEL_10S: period = `BWD_PER_10S;
      `BWD_SEL_50S: period = `BWD_PER_50S;
      default:      period = `BWD_PER_255S;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= `BWD_SEL_RESET;
      cfg_q <= `BWD_CFG_RESET;
    end else begin
      if (wr_ctrl && reg_wdata[`BWD_CTRL_SEL_WE]) begin
        sel_q <= reg_wdata[`BWD_CTRL_SEL_HI:`BWD_CTRL_SEL_LO];
      end
      if (wr_cfg) begin
        cfg_q <= reg_wdata[2:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_q   <= 1'b0;
      secs_q     <= 8'h00;
      tick_cnt_q <= 32'h0;
      expired_q  <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (service) begin
        active_q   <= 1'b1;
        secs_q     <= 8'h00;
        tick_cnt_q <= 32'h0;
      end else if (active_q) begin
        if (tick) begin
          tick_cnt_q <= 32'h0;
          if (secs_q + 8'h01 >= period) begin
            expired_q <= 1'b1;
            secs_q    <= 8'h00;
          end else begin
            secs_q <= secs_q + 8'h01;
          end
        end else begin
          tick_cnt_q <= tick_cnt_q + 32'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Switch routing
  // --------------------------------------------------------------------------
  wire sw_a = ~rsw_n;
  wire sw_b = ~hbtn_n;
  wire rst_src = cfg_q[`BWD_CFG_SWAP] ? sw_b : sw_a;
  wire pwr_src = cfg_q[`BWD_CFG_SWAP] ? sw_a : sw_b;
  wire rst_press = rst_src & ~cfg_q[`BWD_CFG_RST_DIS];
  wire pwr_press = pwr_src & ~cfg_q[`BWD_CFG_PWR_DIS];

  reg [15:0] deb_cnt_q;
  reg        pwr_deb_q;
  reg        pwr_prev_q;
  reg [7:0]  pulse_cnt_q;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      deb_cnt_q          <= 16'h0;
      pwr_deb_q          <= 1'b0;
      pwr_prev_q         <= 1'b0;
      power_button_pulse <= 1'b0;
    end else begin
      if (pwr_press == pwr_deb_q) begin
        deb_cnt_q <= 16'h0;
      end else if (deb_cnt_q == DEB_CYC - 1) begin
        deb_cnt_q <= 16'h0;
        pwr_deb_q <= pwr_press;
      end else begin
        deb_cnt_q <= deb_cnt_q + 16'h1;
      end
      pwr_prev_q         <= pwr_deb_q;
      power_button_pulse <= pwr_deb_q & ~pwr_prev_q;
    end
  end

  // Reset request held while a source is active, then stretched
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_cnt_q      <= 8'h00;
      system_reset_req <= 1'b0;
    end else begin
      if (rst_press || ~bpr_n || expired_q) begin
        pulse_cnt_q <= PULSE_CYC[7:0];
      end else if (pulse_cnt_q != 8'h00) begin
        pulse_cnt_q <= pulse_cnt_q - 8'h01;
      end
      system_reset_req <= rst_press || ~bpr_n || expired_q || (pulse_cnt_q != 8'h00);
    end
  end

  // --------------------------------------------------------------------------
  // Handle and power state
  // --------------------------------------------------------------------------
  reg [31:0] open_cnt_q;
  reg        ps_q;
  reg        unlocked_q;
  reg        boot_q;
  reg        hcl_prev_q;

  // Closed-to-open transition of the handle, the unlock gesture
  wire open_edge = hcl_prev_q & ~hcl;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      open_cnt_q     <= 32'h0;
      ps_q           <= `BWD_PS_S0;
      unlocked_q     <= 1'b0;
      boot_q         <= 1'b1;
      hcl_prev_q     <= 1'b0;
      power_override <= 1'b0;
      soft_off       <= 1'b0;
    end else begin
      boot_q         <= 1'b0;
      hcl_prev_q     <= hcl;
      power_override <= 1'b0;
      if (hcl) begin
        open_cnt_q <= 32'h0;
      end else if (open_cnt_q != OVR_CYC) begin
        open_cnt_q <= open_cnt_q + 32'h1;
      end
      if (ps_q == `BWD_PS_S0) begin
        unlocked_q <= 1'b0;
        if (!hcl && open_cnt_q == OVR_CYC - 1) begin
          power_override <= 1'b1;
          ps_q           <= `BWD_PS_S5;
        end
      end else begin
        if (open_edge) begin
          unlocked_q <= 1'b1;
        end else if (hcl && unlocked_q) begin
          unlocked_q <= 1'b0;
          ps_q       <= `BWD_PS_S0;
        end
      end
      // Open at power-up counts as already unlocked, so a close returns S0
      if (boot_q && !hcl) begin
        ps_q       <= `BWD_PS_S5;
        unlocked_q <= 1'b1;
      end
      soft_off <= (ps_q == `BWD_PS_S5);
    end
  end

  // --------------------------------------------------------------------------
  // Indicator
  // --------------------------------------------------------------------------
  reg [31:0] blink_cnt_q;
  reg        blink_q;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt_q                 <= 32'h0;
      blink_q                     <= 1'b0;
      power_good_indicator_green  <= 1'b0;
      power_good_indicator_yellow <= 1'b0;
    end else begin
      if (blink_cnt_q == BLINK_CYC - 1) begin
        blink_cnt_q <= 32'h0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h1;
      end
      power_good_indicator_yellow <= ~hcl & blink_q;
      power_good_indicator_green  <= hcl & rg & ~system_reset_req & ~ps_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `BWD_REG_CTRL: reg_rdata <= {6'h00, sel_q};
        `BWD_REG_STAT: reg_rdata <= {4'h0, ps_q, ~hcl, rg, active_q};
        `BWD_REG_CFG:  reg_rdata <= {5'h00, cfg_q};
        default:       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // bwd_top

`default_nettype wire

// ---- src/bwd_consts.vh ----
/*
  Constants for the board supervisor: register offsets, field positions,
  reset values and timing figures.
  Assumes a 25 MHz core clock and a plain strobe register port.
*/
`ifndef BWD_CONSTS_VH
`define BWD_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define BWD_ADDR_W          4
`define BWD_REG_CTRL        4'h0
`define BWD_REG_STAT        4'h1
`define BWD_REG_CFG         4'h2

// ----------------------------------------------------------------------------
// Control register fields (write)
// ----------------------------------------------------------------------------
`define BWD_CTRL_SEL_LO     0
`define BWD_CTRL_SEL_HI     1
`define BWD_CTRL_SEL_WE     2
`define BWD_CTRL_SERVICE    3

// ----------------------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------------------
`define BWD_CFG_SWAP        0
`define BWD_CFG_RST_DIS     1
`define BWD_CFG_PWR_DIS     2
`define BWD_CFG_RESET       3'h0

// ----------------------------------------------------------------------------
// Period selections
// ----------------------------------------------------------------------------
`define BWD_SEL_2S          2'h0
`define BWD_SEL_10S         2'h1
`define BWD_SEL_50S         2'h2
`define BWD_SEL_255S        2'h3
`define BWD_SEL_RESET       2'h0
`define BWD_PER_2S          8'h02
`define BWD_PER_10S         8'h0A
`define BWD_PER_50S         8'h32
`define BWD_PER_255S        8'hFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BWD_CLK_HZ          25000000
`define BWD_OVERRIDE_S      4
`define BWD_BLINK_HZ        2
`define BWD_RST_PULSE_CYC   16
`define BWD_DEB_CYC         1024

// ----------------------------------------------------------------------------
// Power states
// ----------------------------------------------------------------------------
`define BWD_PS_S0           1'b0
`define BWD_PS_S5           1'b1

`endif

// ---- src/bwd_sync.v ----
/*
  Three-stage pin synchroniser; the output changes once stages two and
  three agree.
  Assumes an asynchronous input and a single core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module bwd_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire core_clk,
  input  wire sys_rst,
  // Pin
  input  wire pin_in,
  output reg  pin_out
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      pin_out <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        pin_out <= s3_q;
      end
    end
  end

endmodule // bwd_sync

`default_nettype wire

// ---- tb/bwd_checker.sv ----
/*
  Port checker for the board supervisor.
  Bound to bwd_top; sees its ports only.
*/
`include "bwd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module bwd_checker #(
  parameter PULSE_CYC = 16,
  parameter BLINK_CYC = 4
) (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  // Register port
  input wire logic [`BWD_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  // Pins
  input wire logic                   reset_switch_n,
  input wire logic                   handle_button_n,
  input wire logic                   handle_closed,
  input wire logic                   backplane_reset_request_n,
  // Events and indicator
  input wire logic                   system_reset_req,
  input wire logic                   power_button_pulse,
  input wire logic                   power_override,
  input wire logic                   power_good_indicator_green,
  input wire logic                   power_good_indicator_yellow
);
  localparam int BLK_MAX = BLINK_CYC + 1;
  localparam int QUIET   = PULSE_CYC + 16;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Helper state
  // ----
  logic       armed_q;
  logic [7:0] quiet_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      quiet_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `BWD_REG_CTRL && reg_wdata[`BWD_CTRL_SERVICE])
        armed_q <= 1'b1;
      if (!reset_switch_n || !handle_button_n || !backplane_reset_request_n)
        quiet_q <= 8'h00;
      else if (quiet_q != 8'hFF)
        quiet_q <= quiet_q + 8'h01;
    end
  end
  // ----
  // Properties
  // ----
  sequence bp_held_s;
    !backplane_reset_request_n [*8];
  endsequence
  sequence bp_release_s;
    bp_held_s ##1 backplane_reset_request_n;
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  bp_hold_a: assert property (bp_held_s |-> system_reset_req)
    else $error("backplane request not followed");
  bp_stretch_a: assert property (bp_release_s |-> system_reset_req [*8])
    else $error("reset request not stretched");
  btn_single_a: assert property (power_button_pulse |=> !power_button_pulse)
    else $error("power pulse too long");
  ovr_single_a: assert property (power_override |=> !power_override)
    else $error("override pulse too long");
  green_reset_a: assert property (system_reset_req ##1 system_reset_req |-> !power_good_indicator_green)
    else $error("green during reset");
  yellow_off_a: assert property (handle_closed [*8] |-> !power_good_indicator_yellow)
    else $error("yellow with closed handle");
  yellow_blink_a: assert property (!handle_closed [*8] |-> ##[0:BLK_MAX] $changed(power_good_indicator_yellow))
    else $error("yellow not blinking");
  wd_passive_a: assert property (!armed_q && quiet_q > QUIET |-> !system_reset_req)
    else $error("passive watchdog expired");
endmodule // bwd_checker

bind bwd_top bwd_checker #(.PULSE_CYC(PULSE_CYC), .BLINK_CYC(BLINK_CYC)) u_bwd_checker (
  .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .reset_switch_n, .handle_button_n, .handle_closed, .backplane_reset_request_n,
  .system_reset_req, .power_button_pulse, .power_override,
  .power_good_indicator_green, .power_good_indicator_yellow);
`default_nettype wire

// ---- tb/bwd_panel.sv ----
/*
  Front panel, backplane and board reset model.
  Assumes the bench sets pin levels through the pins task.
*/
`timescale 1ns/1ps
`default_nettype none
module bwd_panel (
  // Clock and board reset
  input  wire logic core_clk,
  output wire logic sys_rst,
  // Pins
  output var  logic reset_switch_n,
  output var  logic handle_button_n,
  output var  logic handle_closed,
  output var  logic backplane_reset_request_n,
  output var  logic rails_good,
  // From block
  input  wire logic system_reset_req
);
  int   rst_cnt = 10;
  logic req_q   = 1'b0;
  // Handle open at power-up
  initial begin
    {reset_switch_n, handle_button_n, handle_closed, backplane_reset_request_n, rails_good} = 5'b11011;
  end
  // Full reset once the request ends
  always @(posedge core_clk) begin
    req_q <= system_reset_req;
    if (req_q && !system_reset_req)
      rst_cnt <= 10;
    else if (rst_cnt != 0)
      rst_cnt <= rst_cnt - 1;
  end
  assign sys_rst = rst_cnt != 0;
  task automatic pins(input logic [4:0] v);
    @(posedge core_clk);
    {reset_switch_n, handle_button_n, handle_closed, backplane_reset_request_n, rails_good} <= v;
  endtask
endmodule // bwd_panel
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the board supervisor.
  Assumes the panel model drives pins and board reset.
*/
`include "bwd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       core_clk  = 1'b0;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  wire  [7:0] reg_rdata;
  wire        sys_rst, reset_switch_n, handle_button_n, handle_closed;
  wire        backplane_reset_request_n, rails_good, system_reset_req;
  wire        power_button_pulse, power_override, soft_off;
  wire        power_good_indicator_green, power_good_indicator_yellow;
  int         n_errors = 0;
  int         checked  = 0;
  int         cyc      = 0;
  int         n_pulse  = 0;
  int         n_ovr    = 0;
  int         c;
  int         per [4]  = '{2, 10, 50, 255};
  logic [7:0] cfgs [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
  logic [4:0] pv [4]   = '{5'b01111, 5'b11101, 5'b10111, 5'b01111};
  logic       rq [4]   = '{1'b1, 1'b1, 1'b1, 1'b0};
  bwd_top #(.TICK_CYC(10), .OVR_CYC(40), .BLINK_CYC(4), .DEB_CYC(4)) u_bwd_top (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reset_switch_n, .handle_button_n, .handle_closed, .backplane_reset_request_n,
    .rails_good, .system_reset_req, .power_button_pulse, .power_override,
    .soft_off, .power_good_indicator_green, .power_good_indicator_yellow);
  bwd_panel u_bwd_panel (
    .core_clk, .sys_rst, .reset_switch_n, .handle_button_n, .handle_closed,
    .backplane_reset_request_n, .rails_good, .system_reset_req);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ----
  // Tasks
  // ----
  task automatic compare(input string s, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string s);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 compare(s, reg_rdata, exp);
  endtask
  task automatic wait_req(input int max);
    c = 0;
    while (system_reset_req !== 1'b1 && c < max) begin
      w(1);
      c++;
    end
  endtask
  // Wait out the board reset, then reopen and close the handle
  task automatic reboot();
    c = 0;
    while (sys_rst !== 1'b1 && c < 100) begin
      w(1);
      c++;
    end
    while (sys_rst !== 1'b0 && c < 100) begin
      w(1);
      c++;
    end
    u_bwd_panel.pins(5'b11011);
    w(8);
    u_bwd_panel.pins(5'b11111);
    w(10);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc     <= cyc + 1;
    n_pulse <= n_pulse + (power_button_pulse === 1'b1);
    n_ovr   <= n_ovr + (power_override === 1'b1);
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    w(14);
    compare("boot soft off", {7'h00, soft_off}, 8'h01);
    u_bwd_panel.pins(5'b11111);
    w(10);
    compare("soft off", {7'h00, soft_off}, 8'h00);
    compare("green", {7'h00, power_good_indicator_green}, 8'h01);
    rd(`BWD_REG_STAT, 8'h02, "status");
    rd(`BWD_REG_CFG, {5'h00, `BWD_CFG_RESET}, "config");
    rd(`BWD_REG_CTRL, {6'h00, `BWD_SEL_RESET}, "period");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00, "unmapped");
    u_bwd_panel.pins(5'b11110);
    w(8);
    compare("green rails bad", {7'h00, power_good_indicator_green}, 8'h00);
    u_bwd_panel.pins(5'b10111);
    w(12);
    u_bwd_panel.pins(5'b11111);
    w(12);
    compare("button pulses", n_pulse[7:0], 8'h01);
    u_bwd_panel.pins(5'b11011);
    w(36);
    compare("early override", n_ovr[7:0], 8'h00);
    w(16);
    compare("override", n_ovr[7:0], 8'h01);
    compare("override soft off", {7'h00, soft_off}, 8'h01);
    u_bwd_panel.pins(5'b11111);
    w(10);
    compare("still S5", {7'h00, soft_off}, 8'h01);
    u_bwd_panel.pins(5'b11011);
    w(8);
    u_bwd_panel.pins(5'b11111);
    w(10);
    compare("back to S0", {7'h00, soft_off}, 8'h00);
    done("panel");
    for (int i = 0; i < 4; i++) begin
      wr(`BWD_REG_CTRL, 8'h0C | i[7:0]);
      if (i == 0)
        repeat (3) begin
          w(15);
          wr(`BWD_REG_CTRL, 8'h08);
        end
      wait_req(per[i] * 10 + 10);
      compare("expiry time", {7'h00, c >= per[i] * 10 - 2 && c <= per[i] * 10 + 4}, 8'h01);
      reboot();
      rd(`BWD_REG_CTRL, 8'h00, "period after reset");
    end
    w(100);
    compare("passive", {7'h00, system_reset_req}, 8'h00);
    done("watchdog");
    wr(`BWD_REG_CFG, 8'h06);
    wr(`BWD_REG_CTRL, 8'h0F);
    w(30);
    wr(`BWD_REG_CTRL, 8'h04);
    wait_req(14);
    compare("new period", {7'h00, system_reset_req}, 8'h01);
    reboot();
    done("reprogram");
    for (int i = 0; i < 4; i++) begin
      wr(`BWD_REG_CFG, cfgs[i]);
      u_bwd_panel.pins(pv[i]);
      wait_req(30);
      w(30 - c);
      u_bwd_panel.pins(5'b11111);
      compare("switch reset", {7'h00, c < 30}, {7'h00, rq[i]});
      if (rq[i])
        reboot();
    end
    done("switches");
    results();
  end
endmodule // testbench
`default_nettype wire
